// ===== port_cfg_pkg.sv
package port_cfg_pkg;
  // ---------------------------------------------------------------
  // Register offsets (SFR addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h9f;
  localparam logic [7:0] ADDR_P3_LO_OR_THRESH = 8'hac;
  localparam logic [7:0] ADDR_P3_HI_OR_SLEW = 8'had;
  localparam logic [7:0] ADDR_P3_DATA = 8'hb0;
  localparam logic [7:0] ADDR_P0_LO = 8'hb1;
  localparam logic [7:0] ADDR_P0_HI = 8'hb2;
  localparam logic [7:0] ADDR_STATUS = 8'h9e;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_P0_LO = 8'hff;
  localparam logic [7:0] RST_P0_HI = 8'h00;
  localparam logic RST_P3_LO = 1'b1;
  localparam logic RST_P3_HI = 1'b0;
  localparam logic RST_P3_THRESH = 1'b0;
  localparam logic RST_P3_SLEW = 1'b0;
  localparam logic RST_P3_DATA = 1'b1;
  localparam logic RST_PAGE = 1'b0;
  localparam int PIN0_BIT = 0;
  localparam int PAGE_BIT = 0;
  localparam logic PAGE_0 = 1'b0;
  localparam logic PAGE_1 = 1'b1;

  // ---------------------------------------------------------------
  // Output types, {mode_lo, mode_hi}
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_INPUT_ONLY = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
endpackage

// ===== pin_driver.sv
`timescale 1ns/1ps
module pin_driver (
  input wire logic [1:0] mode_in,
  input wire logic data_in,
  output logic drive_out,
  output logic oe_n_out,
  output logic weak_pull_out
);
  // Quasi mode drives low strongly, high only by a weak pull-up
  wire is_push = (mode_in == port_cfg_pkg::MODE_PUSH_PULL);
  wire is_quasi = (mode_in == port_cfg_pkg::MODE_QUASI);
  wire is_od = (mode_in == port_cfg_pkg::MODE_OPEN_DRAIN);
  wire drives = is_push | ((is_quasi | is_od) & ~data_in);
  assign drive_out = data_in & is_push;
  assign oe_n_out = ~drives;
  assign weak_pull_out = is_quasi & data_in;
endmodule // pin_driver

// ===== port_pin_mode_config.sv
`timescale 1ns/1ps
// Summary of operation
// - Each port 0 pin's type is {lo bit, hi bit}: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - The port 3 pin's type comes from bit 0 of its lo and hi mode registers.
// - Threshold bit 0 picks TTL input when 0 and Schmitt input when 1.
// - Slew bit 0 picks normal slew when 0 and high-speed slew when 1.
// - Port 3 data bits 7 to 1 always read as 0.
// - The port 3 pin is I/O only on the internal oscillator, else the oscillator input.
// - Off the internal oscillator, port 3 data writes are ignored and reads give 0.
// - Shared addresses reach mode registers on page 0 and threshold or slew on page 1.
// - Port 0 hi mode resets to zero, so port 0 starts input-only.
module port_pin_mode_config #(
  parameter int P0_WIDTH = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic INT_OSC_SEL_IN,
  input wire logic [P0_WIDTH-1:0] P0_PIN_IN,
  output logic [P0_WIDTH-1:0] P0_PIN_OUT,
  output logic [P0_WIDTH-1:0] P0_PIN_OE_N_OUT,
  output logic [P0_WIDTH-1:0] P0_WEAK_PULL_OUT,
  output logic [P0_WIDTH-1:0] P0_MODE_PUSH_OUT,
  input wire logic P3_PIN0_IN,
  output logic P3_PIN0_OUT,
  output logic P3_PIN0_OE_N_OUT,
  output logic P3_WEAK_PULL_OUT,
  output logic P3_SCHMITT_OUT,
  output logic P3_FAST_SLEW_OUT,
  output logic EXT_OSC_ROUTE_OUT,
  output logic EXT_OSC_CLK_OUT
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (P0_WIDTH < 1 || P0_WIDTH > 8) begin : g_bad_width
    $error("P0_WIDTH must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [P0_WIDTH-1:0] port0_mode_select_lo;
  logic [P0_WIDTH-1:0] port0_mode_select_hi;
  logic [P0_WIDTH-1:0] port0_data;
  logic port3_mode_select_lo;
  logic port3_mode_select_hi;
  logic port3_input_threshold;
  logic port3_slew_ctrl;
  logic port3_pin_data;
  logic page;
  logic osc_sync1;
  logic osc_sync2;
  logic p3_sync1;
  logic p3_sync2;
  logic [P0_WIDTH-1:0] p0_sync1;
  logic [P0_WIDTH-1:0] p0_sync2;
  logic [7:0] rdata;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Clock select comes from the clock tree, treated as asynchronous
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      p3_sync1 <= 1'b0;
      p3_sync2 <= 1'b0;
      p0_sync1 <= '0;
      p0_sync2 <= '0;
    end else begin
      osc_sync1 <= INT_OSC_SEL_IN;
      osc_sync2 <= osc_sync1;
      p3_sync1 <= P3_PIN0_IN;
      p3_sync2 <= p3_sync1;
      p0_sync1 <= P0_PIN_IN;
      p0_sync2 <= p0_sync1;
    end
  end

  wire gpio_ok = osc_sync2;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire hit_page = (ADDR_IN == port_cfg_pkg::ADDR_PAGE_SEL);
  wire hit_ac = (ADDR_IN == port_cfg_pkg::ADDR_P3_LO_OR_THRESH);
  wire hit_ad = (ADDR_IN == port_cfg_pkg::ADDR_P3_HI_OR_SLEW);
  wire hit_p3 = (ADDR_IN == port_cfg_pkg::ADDR_P3_DATA);
  wire hit_p0lo = (ADDR_IN == port_cfg_pkg::ADDR_P0_LO);
  wire hit_p0hi = (ADDR_IN == port_cfg_pkg::ADDR_P0_HI);
  wire hit_stat = (ADDR_IN == port_cfg_pkg::ADDR_STATUS);
  wire pg0 = (page == port_cfg_pkg::PAGE_0);
  wire pg1 = (page == port_cfg_pkg::PAGE_1);
  wire sel_p3_lo = hit_ac & pg0;
  wire sel_p3_thr = hit_ac & pg1;
  wire sel_p3_hi = hit_ad & pg0;
  wire sel_p3_slew = hit_ad & pg1;
  // Port 0 page 1 holds threshold/slew for other blocks; not mapped here
  wire sel_p0_lo = hit_p0lo & pg0;
  wire sel_p0_hi = hit_p0hi & pg0;
  wire wr_p3_data = WR_IN & hit_p3 & gpio_ok;
  wire wbit0 = WDATA_IN[port_cfg_pkg::PIN0_BIT];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      page <= port_cfg_pkg::RST_PAGE;
      port0_mode_select_lo <= port_cfg_pkg::RST_P0_LO[P0_WIDTH-1:0];
      port0_mode_select_hi <= port_cfg_pkg::RST_P0_HI[P0_WIDTH-1:0];
      port3_mode_select_lo <= port_cfg_pkg::RST_P3_LO;
      port3_mode_select_hi <= port_cfg_pkg::RST_P3_HI;
      port3_input_threshold <= port_cfg_pkg::RST_P3_THRESH;
      port3_slew_ctrl <= port_cfg_pkg::RST_P3_SLEW;
      port3_pin_data <= port_cfg_pkg::RST_P3_DATA;
    end else begin
      if (WR_IN && hit_page) begin
        page <= WDATA_IN[port_cfg_pkg::PAGE_BIT];
      end
      if (WR_IN && sel_p0_lo) begin
        port0_mode_select_lo <= WDATA_IN[P0_WIDTH-1:0];
      end
      if (WR_IN && sel_p0_hi) begin
        port0_mode_select_hi <= WDATA_IN[P0_WIDTH-1:0];
      end
      if (WR_IN && sel_p3_lo) begin
        port3_mode_select_lo <= wbit0;
      end
      if (WR_IN && sel_p3_hi) begin
        port3_mode_select_hi <= wbit0;
      end
      if (WR_IN && sel_p3_thr) begin
        port3_input_threshold <= wbit0;
      end
      if (WR_IN && sel_p3_slew) begin
        port3_slew_ctrl <= wbit0;
      end
      if (wr_p3_data) begin
        port3_pin_data <= wbit0;
      end
    end
  end

  // Port 0 output latch: a data write port is outside this block, so the
  // latch holds ones, letting quasi and open-drain pins float high.
  assign port0_data = '1;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [7:0] p0_lo_rd = 8'(port0_mode_select_lo);
  wire [7:0] p0_hi_rd = 8'(port0_mode_select_hi);
  wire [7:0] p3_lo_rd = {7'h00, port3_mode_select_lo};
  wire [7:0] p3_hi_rd = {7'h00, port3_mode_select_hi};
  wire [7:0] p3_thr_rd = {7'h00, port3_input_threshold};
  wire [7:0] p3_slew_rd = {7'h00, port3_slew_ctrl};
  // Pin level is read, as an 8051 port read does
  wire [7:0] p3_data_rd = {7'h00, p3_sync2 & gpio_ok};
  wire [7:0] page_rd = {7'h00, page};
  wire [7:0] stat_rd = {7'h00, gpio_ok};

  always_comb begin
    rdata = 8'h00;
    if (sel_p3_lo) begin
      rdata = p3_lo_rd;
    end else if (sel_p3_thr) begin
      rdata = p3_thr_rd;
    end else if (sel_p3_hi) begin
      rdata = p3_hi_rd;
    end else if (sel_p3_slew) begin
      rdata = p3_slew_rd;
    end else if (hit_p3) begin
      rdata = p3_data_rd;
    end else if (sel_p0_lo) begin
      rdata = p0_lo_rd;
    end else if (sel_p0_hi) begin
      rdata = p0_hi_rd;
    end else if (hit_page) begin
      rdata = page_rd;
    end else if (hit_stat) begin
      rdata = stat_rd;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      RDATA_OUT <= rdata;
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Port 0 pin drivers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < P0_WIDTH; i++) begin : g_p0
    wire [1:0] mode = {port0_mode_select_lo[i], port0_mode_select_hi[i]};
    pin_driver u_drv (
      .mode_in(mode),
      .data_in(port0_data[i]),
      .drive_out(P0_PIN_OUT[i]),
      .oe_n_out(P0_PIN_OE_N_OUT[i]),
      .weak_pull_out(P0_WEAK_PULL_OUT[i])
    );
    assign P0_MODE_PUSH_OUT[i] = (mode == port_cfg_pkg::MODE_PUSH_PULL);
  end

  // ---------------------------------------------------------------
  // Port 3 pin
  // ---------------------------------------------------------------
  wire [1:0] p3_mode = {port3_mode_select_lo, port3_mode_select_hi};
  logic p3_drive;
  logic p3_oe_n;
  logic p3_weak;

  pin_driver u_p3_drv (
    .mode_in(p3_mode),
    .data_in(port3_pin_data),
    .drive_out(p3_drive),
    .oe_n_out(p3_oe_n),
    .weak_pull_out(p3_weak)
  );

  // As oscillator input the pin is never driven, whatever its mode says
  assign P3_PIN0_OUT = p3_drive & gpio_ok;
  assign P3_PIN0_OE_N_OUT = p3_oe_n | ~gpio_ok;
  assign P3_WEAK_PULL_OUT = p3_weak & gpio_ok;
  assign EXT_OSC_ROUTE_OUT = ~gpio_ok;
  // Raw pin goes straight to the clock tree; synchronising would spoil it
  assign EXT_OSC_CLK_OUT = P3_PIN0_IN & ~gpio_ok;
  assign P3_SCHMITT_OUT = port3_input_threshold;
  assign P3_FAST_SLEW_OUT = port3_slew_ctrl;

  // p0_sync2 is kept for a future data read path; unused bits tied off
  wire unused_ok = &{1'b0, p0_sync2};
endmodule // port_pin_mode_config

// ===== port_cfg_properties.sv
`timescale 1ns/1ps
module port_cfg_checker #(
  parameter int P0_WIDTH = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic INT_OSC_SEL_IN,
  input wire logic [P0_WIDTH-1:0] P0_PIN_OE_N_OUT,
  input wire logic [P0_WIDTH-1:0] P0_MODE_PUSH_OUT,
  input wire logic P3_SCHMITT_OUT,
  input wire logic P3_FAST_SLEW_OUT,
  input wire logic EXT_OSC_ROUTE_OUT
);
  // ------------------------------
  // Shadow of the writable state
  // ------------------------------
  logic page, thr, slw;
  logic [P0_WIDTH-1:0] lo, hi;
  wire a_pg = ADDR_IN == port_cfg_pkg::ADDR_PAGE_SEL;
  wire a_ac = ADDR_IN == port_cfg_pkg::ADDR_P3_LO_OR_THRESH;
  wire a_ad = ADDR_IN == port_cfg_pkg::ADDR_P3_HI_OR_SLEW;
  wire a_lo = ADDR_IN == port_cfg_pkg::ADDR_P0_LO;
  wire a_hi = ADDR_IN == port_cfg_pkg::ADDR_P0_HI;
  wire w0 = WR_IN && !page;
  wire w1 = WR_IN && page;
  wire rd_dat = RD_IN && ADDR_IN == port_cfg_pkg::ADDR_P3_DATA;
  wire rd_cfg = RD_IN && (a_ac || a_ad);
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      page <= 1'b0;
      thr <= 1'b0;
      slw <= 1'b0;
      lo <= '1;
      hi <= '0;
    end else begin
      if (WR_IN && a_pg) page <= WDATA_IN[0];
      if (w1 && a_ac) thr <= WDATA_IN[0];
      if (w1 && a_ad) slw <= WDATA_IN[0];
      if (w0 && a_lo) lo <= WDATA_IN[P0_WIDTH-1:0];
      if (w0 && a_hi) hi <= WDATA_IN[P0_WIDTH-1:0];
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // The sync chain needs three steady samples before the pin follows
  sequence osc_off_s;
    !INT_OSC_SEL_IN [*3];
  endsequence
  sequence osc_steady_s;
    $stable(INT_OSC_SEL_IN) [*3];
  endsequence
  chk_rd_idle: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data not zero outside a read slot");
  chk_data_upper: assert property (rd_dat |=> RDATA_OUT[7:1] == 7'h00)
    else $error("port 3 data upper bits not zero");
  chk_cfg_upper: assert property (rd_cfg |=> RDATA_OUT[7:1] == 7'h00)
    else $error("port 3 config upper bits not zero");
  chk_p0_push: assert property (P0_MODE_PUSH_OUT == (~lo & hi))
    else $error("port 0 push-pull pins wrong");
  chk_p0_input: assert property ((lo & ~hi & ~P0_PIN_OE_N_OUT) == '0)
    else $error("input-only port 0 pin driven");
  chk_p3_thresh: assert property (P3_SCHMITT_OUT == thr)
    else $error("port 3 threshold select wrong");
  chk_p3_slew: assert property (P3_FAST_SLEW_OUT == slw)
    else $error("port 3 slew select wrong");
  chk_osc_route: assert property (osc_steady_s |=>
    EXT_OSC_ROUTE_OUT == !$past(INT_OSC_SEL_IN, 2))
    else $error("oscillator routing wrong");
  chk_osc_read: assert property (osc_off_s ##0 rd_dat |=> !RDATA_OUT[0])
    else $error("port 3 data not zero off internal clock");
endmodule // port_cfg_checker

bind port_pin_mode_config port_cfg_checker #(.P0_WIDTH(P0_WIDTH)) u_chk (
  .SYS_CLK_IN, .RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
  .INT_OSC_SEL_IN, .P0_PIN_OE_N_OUT, .P0_MODE_PUSH_OUT, .P3_SCHMITT_OUT,
  .P3_FAST_SLEW_OUT, .EXT_OSC_ROUTE_OUT
);

// ===== board_model.sv
`timescale 1ns/1ps
module board_model #(
  parameter int P0_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic [P0_WIDTH-1:0] p0_drive_in,
  input wire logic [P0_WIDTH-1:0] p0_oe_n_in,
  input wire logic [P0_WIDTH-1:0] p0_weak_in,
  input wire logic p3_drive_in,
  input wire logic p3_oe_n_in,
  input wire logic p3_weak_in,
  input wire logic osc_route_in,
  output logic [P0_WIDTH-1:0] p0_level_out,
  output logic p3_level_out
);
  // ------------------------------
  // Pin resolution
  // ------------------------------
  // No board pulls: a released line wanders so stale values never pass
  logic wander = 1'b0;
  always @(posedge clk_in) wander <= !wander;
  assign p0_level_out = (~p0_oe_n_in & p0_drive_in)
    | (p0_oe_n_in & (p0_weak_in | {P0_WIDTH{wander}}));
  // A crystal toggles the pin while it is the oscillator input
  assign p3_level_out = osc_route_in ? wander
    : (!p3_oe_n_in ? p3_drive_in : (p3_weak_in | wander));
endmodule // board_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc = 1'b1;
  logic [7:0] rdata, p0_in, p0_out, p0_oe_n, p0_weak, p0_push;
  logic p3_in, p3_out, p3_oe_n, p3_weak, p3_st, p3_fast, route, osc_clk;
  int error_cnt = 0;
  int checks = 0;
  int k;
  logic [31:0] seed = 32'he7fb;
  logic [7:0] regs [6];
  logic [7:0] at [6] = '{8'hb1, 8'hb2, 8'hac, 8'had, 8'hac, 8'had};
  logic [7:0] rv [6] = '{8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PG = port_cfg_pkg::ADDR_PAGE_SEL;
  localparam logic [7:0] DA = port_cfg_pkg::ADDR_P3_DATA;
  port_pin_mode_config #(.P0_WIDTH(8)) dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .INT_OSC_SEL_IN(osc),
    .P0_PIN_IN(p0_in), .P0_PIN_OUT(p0_out), .P0_PIN_OE_N_OUT(p0_oe_n),
    .P0_WEAK_PULL_OUT(p0_weak), .P0_MODE_PUSH_OUT(p0_push),
    .P3_PIN0_IN(p3_in), .P3_PIN0_OUT(p3_out), .P3_PIN0_OE_N_OUT(p3_oe_n),
    .P3_WEAK_PULL_OUT(p3_weak), .P3_SCHMITT_OUT(p3_st),
    .P3_FAST_SLEW_OUT(p3_fast), .EXT_OSC_ROUTE_OUT(route),
    .EXT_OSC_CLK_OUT(osc_clk));
  board_model #(.P0_WIDTH(8)) board (.clk_in(clk), .p0_drive_in(p0_out),
    .p0_oe_n_in(p0_oe_n), .p0_weak_in(p0_weak), .p3_drive_in(p3_out),
    .p3_oe_n_in(p3_oe_n), .p3_weak_in(p3_weak), .osc_route_in(route),
    .p0_level_out(p0_in), .p3_level_out(p3_in));
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(string what, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(what, exp, rdata);
  endtask
  task automatic pick(int n, logic [7:0] d);
    wr_reg(PG, {7'h00, n > 3});
    wr_reg(at[n], d);
    regs[n] = d & ((n < 2) ? 8'hff : 8'h01);
    rd_reg("readback", at[n], regs[n]);
  endtask
  task automatic check_pins();
    logic [7:0] d;
    logic e;
    logic l;
    logic h;
    d = regs[0] ^ regs[1];
    e = regs[2][0] ^ regs[3][0];
    l = regs[2][0];
    h = regs[3][0];
    cmp("p0 push", ~regs[0] & regs[1], p0_push);
    cmp("p0 enable", regs[0] & d, p0_oe_n & d);
    cmp("p3 enable", {7'h00, regs[2][0] & e}, {7'h00, p3_oe_n & e});
    cmp("p3 schmitt", regs[4], {7'h00, p3_st});
    cmp("p3 slew", regs[5], {7'h00, p3_fast});
    // Both latches hold one here, so only push-pull drives high
    cmp("p0 drive", ~regs[0] & regs[1], p0_out);
    cmp("p0 weak", ~regs[0] & ~regs[1], p0_weak);
    cmp("p3 drive", {7'h00, ~l & h}, {7'h00, p3_out});
    cmp("p3 weak", {7'h00, ~l & ~h}, {7'h00, p3_weak});
    cmp("osc route on", 8'h00, {7'h00, route});
    cmp("osc clock on", 8'h00, {7'h00, osc_clk});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------
  // Stimulus
  // ------------------------------
  initial forever #5 clk = !clk;
  initial begin
    #500000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 6; k++) begin
      wr_reg(PG, {7'h00, k > 3});
      rd_reg("reset value", at[k], rv[k]);
      pick(k, 8'hff);
    end
    rd_reg("unmapped", 8'hae, 8'h00);
    rd_reg("page", PG, 8'h01);
    rd_reg("p0 lo page 1", port_cfg_pkg::ADDR_P0_LO, 8'h00);
    rd_reg("status on", port_cfg_pkg::ADDR_STATUS, 8'h01);
    check_pins();
    for (int n = 0; n < 60; n++) begin
      seed = lfsr(seed);
      pick(seed % 6, seed[15:8]);
      check_pins();
    end
    pick(2, 8'h00);
    pick(3, 8'h01);
    wr_reg(DA, 8'hff);
    repeat (3) @(posedge clk);
    rd_reg("p3 data", DA, 8'h01);
    @(posedge clk);
    osc <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    cmp("osc route", 8'h01, {7'h00, route});
    cmp("osc clock", {7'h00, p3_in}, {7'h00, osc_clk});
    wr_reg(DA, 8'h00);
    rd_reg("p3 data off", DA, 8'h00);
    rd_reg("status off", port_cfg_pkg::ADDR_STATUS, 8'h00);
    @(posedge clk);
    osc <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg("p3 data kept", DA, 8'h01);
    test_done();
  end
endmodule // tb
